//--- design/clock_gating_map.svh
// Operation
// - Separate enable sets for run, stop A, stop B
// - Deep stop has no set; all clocks off
// - Peripheral reads need its run-set bit at 1
// - Debug mode never changes enable register behaviour
// - All three sets share one bit layout
// - Register 1 bit 1 gates master two-wire clock
// - Register 1 bit 0 gates slave bus side only
// - Slave bit 0 blocks mailbox access
// - Register 0 bit 6 gates delay block clock
// - Register 0 bit 5 gates PWM timer clock
// - Register 0 bit 4 gates modulo timer clock
// - Register 0 bit 3 off: interrupt pin async only
// - Interrupt pin clock on: both edges usable
// - Register 0 bit 2 gates analog front end clock
// - Register 0 bit 1 gates both port control units
// - Flash bit 0: reads only, no program, no registers
`ifndef CLOCK_GATING_MAP_SVH
`define CLOCK_GATING_MAP_SVH

// Register byte offsets
`define OFS_RUN_0 8'h00
`define OFS_RUN_1 8'h04
`define OFS_STOP_A_0 8'h08
`define OFS_STOP_A_1 8'h0C
`define OFS_STOP_B_0 8'h10
`define OFS_STOP_B_1 8'h14
`define OFS_STATUS 8'h18

// Register 0 field positions
`define BIT_FLASH 0
`define BIT_PORT_CTRL 1
`define BIT_AFE 2
`define BIT_IRQ_PIN 3
`define BIT_MODULO_TIMER 4
`define BIT_PWM_TIMER 5
`define BIT_DELAY_BLOCK 6
// Register 1 field positions
`define BIT_SLAVE_PORT 0
`define BIT_MASTER_TWO_WIRE 1

// Writable bit masks, reserved bits zero
`define MASK_REG_0 8'h7F
`define MASK_REG_1 8'h03

// Reset values: every clock on
`define RESET_REG_0 8'h7F
`define RESET_REG_1 8'h03

// Status field positions
`define STATUS_MODE_LSB 0
`define STATUS_APPLIED_0_LSB 8
`define STATUS_APPLIED_1_LSB 16

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- design/clock_gating_pkg.sv
package clock_gating_pkg;
  // Power mode reported by the power controller
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_STOP_A,
    MODE_STOP_B,
    MODE_DEEP
  } power_mode_t;

  // One enable register, 8 bits wide
  typedef logic [7:0] enable_reg_t;

  // Index order of the peripheral read-allow vector
  typedef enum logic [3:0] {
    PERIPH_FLASH,
    PERIPH_PORT_CTRL,
    PERIPH_AFE,
    PERIPH_IRQ_PIN,
    PERIPH_MODULO_TIMER,
    PERIPH_PWM_TIMER,
    PERIPH_DELAY_BLOCK,
    PERIPH_SLAVE_PORT,
    PERIPH_MASTER_TWO_WIRE
  } periph_index_t;
endpackage : clock_gating_pkg

//--- design/enable_bus_if.sv
interface enable_bus_if;
  clock_gating_pkg::enable_reg_t run_0;     // Run set, register 0
  clock_gating_pkg::enable_reg_t run_1;     // Run set, register 1
  clock_gating_pkg::enable_reg_t stop_a_0;  // Stop A set, register 0
  clock_gating_pkg::enable_reg_t stop_a_1;  // Stop A set, register 1
  clock_gating_pkg::enable_reg_t stop_b_0;  // Stop B set, register 0
  clock_gating_pkg::enable_reg_t stop_b_1;  // Stop B set, register 1
  clock_gating_pkg::power_mode_t mode;      // Current power mode
  clock_gating_pkg::enable_reg_t applied_0; // Enables in force, register 0
  clock_gating_pkg::enable_reg_t applied_1; // Enables in force, register 1

  // Register owner side
  modport owner (
    output run_0, run_1, stop_a_0, stop_a_1, stop_b_0, stop_b_1, mode,
    input applied_0, applied_1
  );
  // Set selector side
  modport selector (
    input run_0, run_1, stop_a_0, stop_a_1, stop_b_0, stop_b_1, mode,
    output applied_0, applied_1
  );
endinterface : enable_bus_if

//--- design/enable_set_select.sv
`include "clock_gating_map.svh"

module enable_set_select (
  input wire logic aclk,
  input wire logic aresetn,
  enable_bus_if.selector bus
);
  clock_gating_pkg::enable_reg_t applied_0;      // Register 0 in force
  clock_gating_pkg::enable_reg_t applied_1;      // Register 1 in force
  clock_gating_pkg::enable_reg_t next_applied_0; // Next register 0
  clock_gating_pkg::enable_reg_t next_applied_1; // Next register 1

  // Same bit meaning in every set, so one loop serves all bits
  for (genvar i = 0; i < 8; i++) begin : g_bit
    // Pick the set that matches the mode
    always_comb begin
      case (bus.mode)
        clock_gating_pkg::MODE_RUN: begin
          next_applied_0[i] = bus.run_0[i];
          next_applied_1[i] = bus.run_1[i];
        end
        clock_gating_pkg::MODE_STOP_A: begin
          next_applied_0[i] = bus.stop_a_0[i];
          next_applied_1[i] = bus.stop_a_1[i];
        end
        clock_gating_pkg::MODE_STOP_B: begin
          next_applied_0[i] = bus.stop_b_0[i];
          next_applied_1[i] = bus.stop_b_1[i];
        end
        default: begin
          // Oscillator stopped: everything off
          next_applied_0[i] = 1'b0;
          next_applied_1[i] = 1'b0;
        end
      endcase
    end
  end

  // Register the selected enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_0 <= `RESET_REG_0;
      applied_1 <= `RESET_REG_1;
    end else begin
      applied_0 <= next_applied_0 & `MASK_REG_0;
      applied_1 <= next_applied_1 & `MASK_REG_1;
    end
  end

  assign bus.applied_0 = applied_0;
  assign bus.applied_1 = applied_1;
endmodule : enable_set_select

//--- design/peripheral_clock_gating.sv
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`include "clock_gating_map.svh"

module peripheral_clock_gating (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Power mode from the power controller
  input wire clock_gating_pkg::power_mode_t power_mode,
  // Peripheral clock enables
  output logic delay_block_clock_enable,
  output logic pwm_timer_clock_enable,
  output logic modulo_timer_clock_enable,
  output logic irq_clock_enable,
  output logic analog_front_end_clock_enable,
  output logic port_control_unit_a_clock_enable,
  output logic port_control_unit_b_clock_enable,
  output logic flash_controller_clock_enable,
  output logic master_two_wire_clock_enable,
  output logic slave_port_bus_clock_enable,
  // Interrupt pin capabilities
  output logic irq_edge_detect_allow,
  output logic irq_async_only,
  // Flash controller permissions
  output logic flash_read_allow,
  output logic flash_program_allow,
  output logic flash_register_access_allow,
  // Slave port permissions
  output logic mailbox_access_allow,
  output logic slave_serial_link_enable,
  // Processor read permission per peripheral
  output logic [8:0] peripheral_read_allow
);

  // Write channel state
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } write_state_t;

  enable_bus_if sets ();

  // Enable register sets
  clock_gating_pkg::enable_reg_t run_0;
  clock_gating_pkg::enable_reg_t run_1;
  clock_gating_pkg::enable_reg_t stop_a_0;
  clock_gating_pkg::enable_reg_t stop_a_1;
  clock_gating_pkg::enable_reg_t stop_b_0;
  clock_gating_pkg::enable_reg_t stop_b_1;
  clock_gating_pkg::enable_reg_t next_run_0;
  clock_gating_pkg::enable_reg_t next_run_1;
  clock_gating_pkg::enable_reg_t next_stop_a_0;
  clock_gating_pkg::enable_reg_t next_stop_a_1;
  clock_gating_pkg::enable_reg_t next_stop_b_0;
  clock_gating_pkg::enable_reg_t next_stop_b_1;

  // Write path holding registers
  write_state_t write_state;
  write_state_t next_write_state;
  logic aw_held;             // Write address captured
  logic next_aw_held;
  logic [7:0] aw_addr;       // Captured write address
  logic [7:0] next_aw_addr;
  logic w_held;              // Write data captured
  logic next_w_held;
  logic [31:0] w_data;       // Captured write data
  logic [31:0] next_w_data;
  logic [3:0] w_strb;        // Captured byte strobes
  logic [3:0] next_w_strb;
  logic [1:0] write_resp;    // Response in flight
  logic [1:0] next_write_resp;
  logic do_write;            // Both halves present

  // Read path registers
  logic read_valid;
  logic next_read_valid;
  logic [31:0] read_data;
  logic [31:0] next_read_data;
  logic [1:0] read_resp;
  logic [1:0] next_read_resp;

  // Permission and gating registers
  logic [8:0] read_allow;
  logic [8:0] next_read_allow;

  // Status word built from live state
  logic [31:0] status_word;

  // Protection bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};

  // Selector applies the set matching the mode
  assign sets.run_0 = run_0;
  assign sets.run_1 = run_1;
  assign sets.stop_a_0 = stop_a_0;
  assign sets.stop_a_1 = stop_a_1;
  assign sets.stop_b_0 = stop_b_0;
  assign sets.stop_b_1 = stop_b_1;
  assign sets.mode = power_mode;

  enable_set_select u_select (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(sets.selector)
  );

  // Handshakes: one transaction of each kind at a time
  assign awready = !aw_held && (write_state == WR_IDLE);
  assign wready = !w_held && (write_state == WR_IDLE);
  assign arready = !read_valid;
  assign do_write = aw_held && w_held && (write_state == WR_IDLE);

  // Write channel: capture, commit, respond
  always_comb begin
    next_write_state = write_state;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_write_resp = write_resp;
    case (write_state)
      WR_IDLE: begin
        // Take address and data in either order
        if (awvalid && awready) begin
          next_aw_held = 1'b1;
          next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
          next_w_held = 1'b1;
          next_w_data = wdata;
          next_w_strb = wstrb;
        end
        // Commit once both halves are held
        if (do_write) begin
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_write_state = WR_RESP;
          case (aw_addr)
            `OFS_RUN_0, `OFS_RUN_1, `OFS_STOP_A_0, `OFS_STOP_A_1,
            `OFS_STOP_B_0, `OFS_STOP_B_1, `OFS_STATUS: begin
              next_write_resp = `RESP_OKAY;
            end
            default: begin
              // Unmapped address
              next_write_resp = `RESP_SLVERR;
            end
          endcase
        end
      end
      WR_RESP: begin
        // Hold response until accepted
        if (bready) begin
          next_write_state = WR_IDLE;
        end
      end
      default: begin
        next_write_state = WR_IDLE;
      end
    endcase
  end

  // Register updates; debug mode plays no part here
  always_comb begin
    next_run_0 = run_0;
    next_run_1 = run_1;
    next_stop_a_0 = stop_a_0;
    next_stop_a_1 = stop_a_1;
    next_stop_b_0 = stop_b_0;
    next_stop_b_1 = stop_b_1;
    if (do_write && w_strb[0]) begin
      case (aw_addr)
        // Reserved bits dropped on write
        `OFS_RUN_0: next_run_0 = w_data[7:0] & `MASK_REG_0;
        `OFS_RUN_1: next_run_1 = w_data[7:0] & `MASK_REG_1;
        `OFS_STOP_A_0: next_stop_a_0 = w_data[7:0] & `MASK_REG_0;
        `OFS_STOP_A_1: next_stop_a_1 = w_data[7:0] & `MASK_REG_1;
        `OFS_STOP_B_0: next_stop_b_0 = w_data[7:0] & `MASK_REG_0;
        `OFS_STOP_B_1: next_stop_b_1 = w_data[7:0] & `MASK_REG_1;
        default: begin
          // Status and unmapped writes change nothing
          next_run_0 = run_0;
        end
      endcase
    end
  end

  // Status: mode and enables in force
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STATUS_MODE_LSB +: 2] = power_mode;
    status_word[`STATUS_APPLIED_0_LSB +: 8] = sets.applied_0;
    status_word[`STATUS_APPLIED_1_LSB +: 8] = sets.applied_1;
  end

  // Read channel: one cycle from address to data
  always_comb begin
    next_read_valid = read_valid;
    next_read_data = read_data;
    next_read_resp = read_resp;
    if (read_valid && rready) begin
      next_read_valid = 1'b0;
    end
    if (arvalid && arready) begin
      next_read_valid = 1'b1;
      next_read_resp = `RESP_OKAY;
      // Reserved bits are stored as zero
      case (araddr)
        `OFS_RUN_0: next_read_data = {24'h00_0000, run_0};
        `OFS_RUN_1: next_read_data = {24'h00_0000, run_1};
        `OFS_STOP_A_0: next_read_data = {24'h00_0000, stop_a_0};
        `OFS_STOP_A_1: next_read_data = {24'h00_0000, stop_a_1};
        `OFS_STOP_B_0: next_read_data = {24'h00_0000, stop_b_0};
        `OFS_STOP_B_1: next_read_data = {24'h00_0000, stop_b_1};
        `OFS_STATUS: next_read_data = status_word;
        default: begin
          // Unmapped address
          next_read_data = 32'h0000_0000;
          next_read_resp = `RESP_SLVERR;
        end
      endcase
    end
  end

  // Processor access permissions follow the run set only
  always_comb begin
    next_read_allow = 9'h000;
    next_read_allow[clock_gating_pkg::PERIPH_FLASH] = run_0[`BIT_FLASH];
    next_read_allow[clock_gating_pkg::PERIPH_PORT_CTRL] = run_0[`BIT_PORT_CTRL];
    next_read_allow[clock_gating_pkg::PERIPH_AFE] = run_0[`BIT_AFE];
    next_read_allow[clock_gating_pkg::PERIPH_IRQ_PIN] = run_0[`BIT_IRQ_PIN];
    next_read_allow[clock_gating_pkg::PERIPH_MODULO_TIMER] = run_0[`BIT_MODULO_TIMER];
    next_read_allow[clock_gating_pkg::PERIPH_PWM_TIMER] = run_0[`BIT_PWM_TIMER];
    next_read_allow[clock_gating_pkg::PERIPH_DELAY_BLOCK] = run_0[`BIT_DELAY_BLOCK];
    next_read_allow[clock_gating_pkg::PERIPH_SLAVE_PORT] = run_1[`BIT_SLAVE_PORT];
    next_read_allow[clock_gating_pkg::PERIPH_MASTER_TWO_WIRE] =
      run_1[`BIT_MASTER_TWO_WIRE];
  end

  // Register every state group
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_0 <= `RESET_REG_0;
      run_1 <= `RESET_REG_1;
      stop_a_0 <= `RESET_REG_0;
      stop_a_1 <= `RESET_REG_1;
      stop_b_0 <= `RESET_REG_0;
      stop_b_1 <= `RESET_REG_1;
      write_state <= WR_IDLE;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      write_resp <= `RESP_OKAY;
      read_valid <= 1'b0;
      read_data <= 32'h0000_0000;
      read_resp <= `RESP_OKAY;
      read_allow <= 9'h1FF;
    end else begin
      run_0 <= next_run_0;
      run_1 <= next_run_1;
      stop_a_0 <= next_stop_a_0;
      stop_a_1 <= next_stop_a_1;
      stop_b_0 <= next_stop_b_0;
      stop_b_1 <= next_stop_b_1;
      write_state <= next_write_state;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      write_resp <= next_write_resp;
      read_valid <= next_read_valid;
      read_data <= next_read_data;
      read_resp <= next_read_resp;
      read_allow <= next_read_allow;
    end
  end

  // Bus answer outputs
  assign bvalid = (write_state == WR_RESP);
  assign bresp = write_resp;
  assign rvalid = read_valid;
  assign rdata = read_data;
  assign rresp = read_resp;
  assign peripheral_read_allow = read_allow;

  // Peripheral clock enables from the applied set
  assign delay_block_clock_enable = sets.applied_0[`BIT_DELAY_BLOCK];
  assign pwm_timer_clock_enable = sets.applied_0[`BIT_PWM_TIMER];
  assign modulo_timer_clock_enable = sets.applied_0[`BIT_MODULO_TIMER];
  assign irq_clock_enable = sets.applied_0[`BIT_IRQ_PIN];
  assign analog_front_end_clock_enable = sets.applied_0[`BIT_AFE];
  // One bit drives both port control units
  assign port_control_unit_a_clock_enable = sets.applied_0[`BIT_PORT_CTRL];
  assign port_control_unit_b_clock_enable = sets.applied_0[`BIT_PORT_CTRL];
  assign flash_controller_clock_enable = sets.applied_0[`BIT_FLASH];
  assign master_two_wire_clock_enable = sets.applied_1[`BIT_MASTER_TWO_WIRE];
  assign slave_port_bus_clock_enable = sets.applied_1[`BIT_SLAVE_PORT];

  // Edge detection needs the pin clock; otherwise only async interrupts
  assign irq_edge_detect_allow = sets.applied_0[`BIT_IRQ_PIN];
  assign irq_async_only = !sets.applied_0[`BIT_IRQ_PIN];

  // Flash array reads never depend on the controller clock
  assign flash_read_allow = 1'b1;
  assign flash_program_allow = sets.applied_0[`BIT_FLASH];
  assign flash_register_access_allow = sets.applied_0[`BIT_FLASH];

  // Mailbox needs the bus-side clock; serial link is clocked externally
  assign mailbox_access_allow = sets.applied_1[`BIT_SLAVE_PORT];
  assign slave_serial_link_enable = 1'b1;

endmodule : peripheral_clock_gating

//--- testbench/clock_gating_checker.sv
module clock_gating_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire clock_gating_pkg::power_mode_t power_mode,
  input wire logic port_control_unit_a_clock_enable,
  input wire logic port_control_unit_b_clock_enable,
  input wire logic irq_clock_enable,
  input wire logic irq_edge_detect_allow,
  input wire logic irq_async_only,
  input wire logic flash_controller_clock_enable,
  input wire logic flash_read_allow,
  input wire logic flash_program_allow,
  input wire logic flash_register_access_allow,
  input wire logic slave_port_bus_clock_enable,
  input wire logic mailbox_access_allow,
  input wire logic slave_serial_link_enable,
  input wire logic [8:0] peripheral_read_allow
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain for every property
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both port control units follow one bit
  AST_PORT_PAIR:
    assert property (port_control_unit_a_clock_enable == port_control_unit_b_clock_enable)
    else $error("port control enables differ");
  // Deep stop leaves the clocks off
  AST_DEEP_OFF:
    assert property ($past(aresetn) && $past(power_mode) == clock_gating_pkg::MODE_DEEP
      |-> !(flash_controller_clock_enable || irq_clock_enable
      || slave_port_bus_clock_enable || port_control_unit_a_clock_enable))
    else $error("clock on in deep stop");
  // Stopped pin clock leaves only async interrupts
  AST_IRQ_ASYNC:
    assert property (!irq_clock_enable |-> irq_async_only && !irq_edge_detect_allow)
    else $error("pin clock off but edges allowed");
  // Running pin clock allows both edges
  AST_IRQ_EDGE:
    assert property (irq_clock_enable |-> irq_edge_detect_allow && !irq_async_only)
    else $error("pin clock on but edges refused");
  // Flash reads always, program and registers only when clocked
  AST_FLASH:
    assert property (flash_read_allow && flash_program_allow == flash_controller_clock_enable
      && flash_register_access_allow == flash_controller_clock_enable)
    else $error("flash permissions wrong");
  // Mailbox access follows the slave bus clock
  AST_MAILBOX:
    assert property (mailbox_access_allow == slave_port_bus_clock_enable)
    else $error("mailbox access wrong");
  // External serial link never gated
  AST_LINK:
    assert property (slave_serial_link_enable)
    else $error("slave link disabled");
  // Read permission ignores the mode, moves only after a write
  AST_READ_ALLOW:
    assert property ($past(aresetn) && !$past(bvalid) && !$past(bvalid, 2)
      |-> $stable(peripheral_read_allow))
    else $error("read permission moved without a write");
  // Write answered two edges after both halves are taken
  AST_WRITE_LAT:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  // Read data holds until taken
  AST_READ_HOLD:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule : clock_gating_checker

//--- testbench/test_peripheral_clock_gating.sv
module test_peripheral_clock_gating;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  clock_gating_pkg::power_mode_t power_mode;
  logic delay_block_clock_enable, pwm_timer_clock_enable, modulo_timer_clock_enable;
  logic irq_clock_enable, analog_front_end_clock_enable, flash_controller_clock_enable;
  logic port_control_unit_a_clock_enable, port_control_unit_b_clock_enable;
  logic master_two_wire_clock_enable, slave_port_bus_clock_enable;
  logic irq_edge_detect_allow, irq_async_only, flash_read_allow, flash_program_allow;
  logic flash_register_access_allow, mailbox_access_allow, slave_serial_link_enable;
  logic [8:0] peripheral_read_allow;
  int errors, checks_done;
  // Shadow of the six enable registers
  logic [7:0] sh [6] = '{8'h7F, 8'h03, 8'h7F, 8'h03, 8'h7F, 8'h03};
  // All clock enables, register 1 bits on top
  wire logic [9:0] en = {master_two_wire_clock_enable, slave_port_bus_clock_enable,
    delay_block_clock_enable, pwm_timer_clock_enable, modulo_timer_clock_enable,
    irq_clock_enable, analog_front_end_clock_enable, port_control_unit_a_clock_enable,
    port_control_unit_b_clock_enable, flash_controller_clock_enable};
  // One case: address, write data, mode, readback
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [1:0] mode;
    logic [7:0] rd;
  } row_t;
  row_t rows [14] = '{'{8'h00, 32'hFFFFFFBF, 2'h0, 8'h3F}, '{8'h00, 32'hDF, 2'h0, 8'h5F},
    '{8'h00, 32'hEF, 2'h0, 8'h6F}, '{8'h00, 32'hF7, 2'h0, 8'h77}, '{8'h00, 32'hFB, 2'h0, 8'h7B},
    '{8'h00, 32'hFD, 2'h0, 8'h7D}, '{8'h00, 32'hFE, 2'h0, 8'h7E}, '{8'h04, 32'hFD, 2'h0, 8'h01},
    '{8'h04, 32'hFE, 2'h0, 8'h02}, '{8'h08, 32'h2A, 2'h1, 8'h2A}, '{8'h0C, 32'h01, 2'h1, 8'h01},
    '{8'h10, 32'hD5, 2'h2, 8'h55}, '{8'h14, 32'h02, 2'h2, 8'h02}, '{8'h00, 32'h00, 2'h3, 8'h00}};

  peripheral_clock_gating i_dut (.*);

  // Expected enables for a mode, deep stop all off
  function automatic logic [9:0] exp_en(input logic [1:0] m);
    if (m == 2'h3) begin
      return 10'h000;
    end
    return {sh[2 * m + 1][1:0], sh[2 * m][6:1], sh[2 * m][1:0]};
  endfunction : exp_en

  // Ends the run with counts and verdict
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  // One clock edge, giving up after a bound
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 50) begin
      errors++;
      wrap_up();
    end
  endtask : tick

  // Write: address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      tick(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  // Read: rready raised late so data must hold
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      tick(n);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // Free running clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    errors = 0;
    checks_done = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    power_mode = clock_gating_pkg::MODE_RUN;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, all clocks on
    for (int i = 0; i < 6; i++) begin
      axi_read(8'(4 * i), d, r);
      check(d, {24'h0, sh[i]});
    end
    // Pin clock is on from reset, before any interrupt setup
    check(32'(en), 32'h3FF);
    check(32'(peripheral_read_allow), 32'h1FF);
    // Table cases: run set one bit at a time, stop sets with mixed patterns, each set under its mode
    foreach (rows[i]) begin
      axi_write(rows[i].addr, rows[i].data, 4'hF, r);
      check(32'(r), 32'h0);
      sh[rows[i].addr[4:2]] = rows[i].rd;
      power_mode <= clock_gating_pkg::power_mode_t'(rows[i].mode);
      repeat (3) @(posedge aclk);
      axi_read(rows[i].addr, d, r);
      check(d, {24'h0, rows[i].rd});
      check(32'(en), 32'(exp_en(power_mode)));
      check(32'(peripheral_read_allow), 32'({sh[1][1:0], sh[0][6:0]}));
    end
    // Status shows deep mode and nothing applied
    axi_read(8'h18, d, r);
    check(d, 32'h0000_0003);
    // Unmapped places refused, nothing changes
    axi_write(8'h40, 32'hFF, 4'hF, r);
    check(32'(r), 32'h2);
    // Status is read only: write answered, nothing stored
    axi_write(8'h18, 32'hFF, 4'hF, r);
    check(32'(r), 32'h0);
    axi_read(8'h1C, d, r);
    check(32'(r), 32'h2);
    // Disabled byte strobe leaves the register alone
    axi_write(8'h00, 32'h7F, 4'h0, r);
    axi_read(8'h00, d, r);
    check(d, 32'h0);
    // Mode sweep with no writes between
    axi_write(8'h00, 32'h35, 4'hF, r);
    sh[0] = 8'h35;
    for (int m = 0; m < 4; m++) begin
      power_mode <= clock_gating_pkg::power_mode_t'(m);
      repeat (2) @(posedge aclk);
      check(32'(en), 32'(exp_en(2'(m))));
      check(32'(peripheral_read_allow), 32'({sh[1][1:0], sh[0][6:0]}));
    end
    // Second reset in mid run restores all clocks
    aresetn <= 1'b0;
    power_mode <= clock_gating_pkg::MODE_RUN;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(8'h00, d, r);
    check(d, 32'h7F);
    check(32'(en), 32'h3FF);
    wrap_up();
  end
endmodule : test_peripheral_clock_gating

// Checker sees only the top ports
bind peripheral_clock_gating clock_gating_checker i_chk (.*);
